/* src/debug_port_security_lock.sv */
// Purpose: Lockout of debug, test and programming ports by a one-time key
// Assumes: All request inputs come from logic on i_ref_clk
// Notes:   Latch cells and protection level survive reset unless i_cell_restore loads the power-up image
`timescale 1ns/1ps
module debug_port_security_lock (
  input wire logic i_ref_clk, // 100 MHz clock
  input wire logic i_rst, // Synchronous reset, active high
  input wire logic i_key_load, // Pulse: load key into volatile stage
  input wire logic [lock_pkg::KEY_W-1:0] i_key_data, // Key value
  input wire logic i_key_commit, // Pulse: program volatile stage into cells
  input wire logic i_cell_restore, // During reset: load power-up cell image
  input wire logic [lock_pkg::KEY_W-1:0] i_cell_data, // Power-up cell image
  input wire logic [lock_pkg::PROT_W-1:0] i_prot_image, // Power-up protection level
  input wire logic i_prot_set, // Pulse: raise protection level
  input wire logic [lock_pkg::PROT_W-1:0] i_prot_level, // Requested level
  input wire logic i_full_erase, // Pulse: full-device erase
  input wire logic i_blk_req, // Pulse: block erase/program/verify request
  input wire logic [lock_pkg::BLK_IDX_W-1:0] i_blk_idx, // Block index
  input wire logic [lock_pkg::BLK_N-1:0] i_blk_permit, // Per-block permission
  input wire logic i_test_req, // Level: test mode wanted
  input wire logic [lock_pkg::SEL_W-1:0] i_dbg_sel, // Debug port choice
  input wire logic [lock_pkg::SEL_W-1:0] i_trace_sel, // Trace port choice
  input wire logic i_readback_req, // Pulse: read latch cells
  output logic o_locked, // Sampled lock, level
  output logic o_armed, // Key committed, waits for reset
  output logic o_key_rejected, // Pulse: key load or commit refused
  output logic [lock_pkg::PROT_W-1:0] o_prot_level, // Current protection level
  output logic o_blk_grant, // Pulse: block operation allowed
  output logic o_blk_deny, // Pulse: block operation refused
  output logic o_test_en, // Test mode enable
  output logic o_jtag_en, // JTAG port enable
  output logic o_swd_en, // SWD port enable
  output logic o_swv_en, // SWV output enable on JTAG data-out pin
  output logic [lock_pkg::TRACE_PINS-1:0] o_trace_oe, // Parallel trace pin enables
  output logic o_cfg_illegal, // Requested port pairing refused
  output logic [lock_pkg::KEY_W-1:0] o_readback_data, // Latch cell readback
  output logic o_readback_valid // Pulse: readback data valid
);

  // ==========================================================================
  // State and vote
  // ==========================================================================
  lock_pkg::lock_st_t st_ff;
  lock_pkg::lock_st_t nxt_st;
  key_vote_if vif ();
  logic open_acc;
  logic no_prot;
  logic legal;
  logic key_open;

  assign vif.cells = st_ff.nv;

  key_vote u_vote (
    .vif(vif.voter)
  );

  assign open_acc = ~st_ff.locked;
  assign no_prot = (st_ff.prot == lock_pkg::PROT_NONE);
  assign key_open = open_acc && no_prot;

  // ==========================================================================
  // Port pairing check
  // ==========================================================================
  always_comb begin
    legal = 1'b0;
    // SWV would collide with JTAG on the shared pin, so that pairing is absent
    case ({i_dbg_sel, i_trace_sel})
      {lock_pkg::DBG_NONE, lock_pkg::TRC_NONE},
      {lock_pkg::DBG_NONE, lock_pkg::TRC_SWV},
      {lock_pkg::DBG_NONE, lock_pkg::TRC_PORT},
      {lock_pkg::DBG_JTAG, lock_pkg::TRC_NONE},
      {lock_pkg::DBG_JTAG, lock_pkg::TRC_PORT},
      {lock_pkg::DBG_SWD, lock_pkg::TRC_NONE},
      {lock_pkg::DBG_SWD, lock_pkg::TRC_SWV},
      {lock_pkg::DBG_SWD, lock_pkg::TRC_PORT}: begin
        legal = 1'b1;
      end
      default: begin
        legal = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    nxt_st = st_ff;
    nxt_st.key_rej = 1'b0;
    nxt_st.blk_grant = 1'b0;
    nxt_st.blk_deny = 1'b0;
    nxt_st.rd_valid = 1'b0;

    // Load may repeat until commit; commit freezes the key until reset
    case (st_ff.fsm)
      lock_pkg::PROG_IDLE: begin
        if (i_key_load) begin
          if (key_open) begin
            nxt_st.vol = i_key_data;
            nxt_st.fsm = lock_pkg::PROG_LOADED;
          end else begin
            nxt_st.key_rej = 1'b1;
          end
        end else if (i_key_commit) begin
          nxt_st.key_rej = 1'b1;
        end
      end
      lock_pkg::PROG_LOADED: begin
        if (i_key_load) begin
          if (key_open) begin
            nxt_st.vol = i_key_data;
          end else begin
            nxt_st.key_rej = 1'b1;
          end
        end else if (i_key_commit) begin
          if (key_open) begin
            nxt_st.nv = st_ff.vol;
            nxt_st.fsm = lock_pkg::PROG_ARMED;
          end else begin
            nxt_st.key_rej = 1'b1;
          end
        end
      end
      lock_pkg::PROG_ARMED: begin
        // Cells are committed; nothing more is taken until the next reset
        if (i_key_load || i_key_commit) begin
          nxt_st.key_rej = 1'b1;
        end
      end
      default: begin
        nxt_st.fsm = lock_pkg::PROG_IDLE;
        nxt_st.key_rej = i_key_load || i_key_commit;
      end
    endcase

    if (i_full_erase && open_acc) begin
      nxt_st.prot = lock_pkg::PROT_NONE;
    end else if (i_prot_set && open_acc && (i_prot_level > st_ff.prot)) begin
      nxt_st.prot = i_prot_level;
    end

    if (i_blk_req) begin
      if (open_acc && i_blk_permit[i_blk_idx]) begin
        nxt_st.blk_grant = 1'b1;
      end else begin
        nxt_st.blk_deny = 1'b1;
      end
    end

    nxt_st.test_en = open_acc && i_test_req;
    nxt_st.illegal = ~legal;
    nxt_st.jtag_en = open_acc && legal && (i_dbg_sel == lock_pkg::DBG_JTAG);
    nxt_st.swd_en = open_acc && legal && (i_dbg_sel == lock_pkg::DBG_SWD);
    nxt_st.swv_en = open_acc && legal && (i_trace_sel == lock_pkg::TRC_SWV);
    nxt_st.tport_en = open_acc && legal && (i_trace_sel == lock_pkg::TRC_PORT);

    if (i_readback_req) begin
      nxt_st.rd_data = st_ff.nv;
      nxt_st.rd_valid = 1'b1;
    end

    if (i_rst) begin
      nxt_st.fsm = lock_pkg::PROG_IDLE;
      nxt_st.vol = lock_pkg::KEY_RST;
      nxt_st.key_rej = 1'b0;
      nxt_st.blk_grant = 1'b0;
      nxt_st.blk_deny = 1'b0;
      nxt_st.test_en = 1'b0;
      nxt_st.jtag_en = 1'b0;
      nxt_st.swd_en = 1'b0;
      nxt_st.swv_en = 1'b0;
      nxt_st.tport_en = 1'b0;
      nxt_st.illegal = 1'b0;
      nxt_st.rd_data = lock_pkg::KEY_RST;
      nxt_st.rd_valid = 1'b0;
      nxt_st.nv = st_ff.nv;
      nxt_st.prot = st_ff.prot;
      if (i_cell_restore) begin
        nxt_st.nv = i_cell_data;
        nxt_st.prot = i_prot_image;
      end
      nxt_st.locked = vif.match;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    st_ff <= nxt_st;
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Enables and pulses come straight from state flip-flops
  assign o_locked = st_ff.locked;
  assign o_armed = (st_ff.fsm == lock_pkg::PROG_ARMED);
  assign o_key_rejected = st_ff.key_rej;
  assign o_prot_level = st_ff.prot;
  assign o_blk_grant = st_ff.blk_grant;
  assign o_blk_deny = st_ff.blk_deny;
  assign o_test_en = st_ff.test_en;
  assign o_jtag_en = st_ff.jtag_en;
  assign o_swd_en = st_ff.swd_en;
  assign o_swv_en = st_ff.swv_en;
  assign o_trace_oe = st_ff.tport_en ? lock_pkg::TRACE_OE_ALL : lock_pkg::TRACE_OE_OFF;
  assign o_cfg_illegal = st_ff.illegal;
  assign o_readback_data = st_ff.rd_data;
  assign o_readback_valid = st_ff.rd_valid;

endmodule // debug_port_security_lock

/* src/lock_pkg.sv */
// Purpose: Shared constants and types for the debug port security lock
// Assumes: One 100 MHz clock, synchronous active-high reset
// Notes:   Storage widths are fixed; nothing here is meant to be overridden
package lock_pkg;

  // ==========================================================================
  // Key latch and vote
  // ==========================================================================
  localparam int KEY_W = 32;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] VOTE_MIN = 6'h1c;
  // Arbitrary value, chosen only for this code base
  localparam logic [KEY_W-1:0] KEY_PATTERN = 32'h1234_abcd;
  localparam logic [KEY_W-1:0] KEY_RST = 32'h0000_0000;

  // ==========================================================================
  // Flash protection and block permissions
  // ==========================================================================
  localparam int PROT_W = 2;
  localparam logic [PROT_W-1:0] PROT_NONE = 2'h0;
  localparam int BLK_N = 16;
  localparam int BLK_IDX_W = 4;

  // ==========================================================================
  // Debug and trace selection
  // ==========================================================================
  localparam int SEL_W = 2;
  localparam logic [SEL_W-1:0] DBG_NONE = 2'h0;
  localparam logic [SEL_W-1:0] DBG_JTAG = 2'h1;
  localparam logic [SEL_W-1:0] DBG_SWD = 2'h2;
  localparam logic [SEL_W-1:0] TRC_NONE = 2'h0;
  localparam logic [SEL_W-1:0] TRC_SWV = 2'h1;
  localparam logic [SEL_W-1:0] TRC_PORT = 2'h2;
  localparam int TRACE_PINS = 5;
  localparam logic [TRACE_PINS-1:0] TRACE_OE_ALL = 5'h1f;
  localparam logic [TRACE_PINS-1:0] TRACE_OE_OFF = 5'h00;

  // ==========================================================================
  // Key programming sequence
  // ==========================================================================
  typedef enum logic [2:0] {
    PROG_IDLE   = 3'b001,
    PROG_LOADED = 3'b010,
    PROG_ARMED  = 3'b100
  } prog_t;

  typedef struct packed {
    prog_t fsm;
    logic [KEY_W-1:0] vol;
    logic [KEY_W-1:0] nv;
    logic locked;
    logic [PROT_W-1:0] prot;
    logic key_rej;
    logic blk_grant;
    logic blk_deny;
    logic test_en;
    logic jtag_en;
    logic swd_en;
    logic swv_en;
    logic tport_en;
    logic illegal;
    logic [KEY_W-1:0] rd_data;
    logic rd_valid;
  } lock_st_t;

endpackage

/* src/key_vote_if.sv */
// Purpose: Carries the latch cells to the vote and the vote result back
// Assumes: Purely combinational path
// Notes:   One modport per side
`timescale 1ns/1ps
interface key_vote_if;
  logic [lock_pkg::KEY_W-1:0] cells;
  logic match;
  modport voter (input cells, output match);
  modport owner (output cells, input match);
endinterface

/* src/key_vote.sv */
// Purpose: Super-majority vote of the latch cells against the key pattern
// Assumes: Cells are stable while read
// Notes:   A few failed bits do not drop the result
`timescale 1ns/1ps
module key_vote (
  key_vote_if.voter vif // Cells in, match out
);

  logic [lock_pkg::CNT_W-1:0] hits;

  always_comb begin
    hits = '0;
    for (int i = 0; i < lock_pkg::KEY_W; i++) begin
      hits = hits + lock_pkg::CNT_W'(~(vif.cells[i] ^ lock_pkg::KEY_PATTERN[i]));
    end
  end

  assign vif.match = (hits >= lock_pkg::VOTE_MIN);

endmodule // key_vote

/* verification/lock_sva.sv */
// Purpose: Port-level checks for the security lock
// Assumes: Bound to the top module, one clock domain
// Notes: All checks are masked while reset is high
`timescale 1ns/1ps
module lock_sva (
  input wire logic i_ref_clk, // Clock
  input wire logic i_rst, // Reset
  input wire logic i_key_load, // Key load
  input wire logic i_blk_req, // Block request
  input wire logic [3:0] i_blk_idx, // Block index
  input wire logic [15:0] i_blk_permit, // Permissions
  input wire logic [1:0] i_dbg_sel, // Debug choice
  input wire logic [1:0] i_trace_sel, // Trace choice
  input wire logic i_readback_req, // Readback
  input wire logic i_full_erase, // Erase
  input wire logic o_locked, // Lock
  input wire logic o_key_rejected, // Refusal
  input wire logic [1:0] o_prot_level, // Protection
  input wire logic o_blk_grant, // Grant
  input wire logic o_blk_deny, // Deny
  input wire logic o_test_en, // Test
  input wire logic o_jtag_en, // JTAG
  input wire logic o_swd_en, // SWD
  input wire logic o_swv_en, // SWV
  input wire logic [4:0] o_trace_oe, // Trace pins
  input wire logic o_cfg_illegal, // Bad pairing
  input wire logic o_readback_valid // Readback valid
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  logic dark;
  assign dark = !o_test_en && !o_jtag_en && !o_swd_en && !o_swv_en && o_trace_oe == 5'h00;
  chk_lock_gates_all: assert property (o_locked |-> dark) else $error("port open while locked");
  chk_lock_holds: assert property ($past(!i_rst) |-> $stable(o_locked)) else $error("lock moved");
  chk_load_locked: assert property (i_key_load && o_locked |=> o_key_rejected) else $error("load taken");
  chk_load_prot: assert property (i_key_load && o_prot_level != 2'h0 |=> o_key_rejected) else $error("load ok");
  chk_blk_deny: assert property (i_blk_req && (o_locked || !i_blk_permit[i_blk_idx])
    |=> o_blk_deny && !o_blk_grant) else $error("block not denied");
  chk_blk_grant: assert property (i_blk_req && !o_locked && i_blk_permit[i_blk_idx]
    |=> o_blk_grant && !o_blk_deny) else $error("block not granted");
  chk_pair_refused: assert property (!o_locked && i_dbg_sel == 2'h1 && i_trace_sel == 2'h1
    |=> o_cfg_illegal && !o_jtag_en && !o_swv_en) else $error("pairing taken");
  chk_readback_pulse: assert property (i_readback_req |=> o_readback_valid ##1
    o_readback_valid == $past(i_readback_req)) else $error("readback pulse");
  chk_prot_no_drop: assert property (!i_full_erase |=> o_prot_level >= $past(o_prot_level))
    else $error("protection dropped");
  cover property (o_locked && o_blk_deny);
  cover property (o_readback_valid);
  cover property (o_cfg_illegal);
endmodule // lock_sva
bind debug_port_security_lock lock_sva u_sva (.*);

/* verification/key_host.sv */
// Purpose: Programmer model that writes the key
// Assumes: Acts on the rising clock edge
// Notes: Released key lines toggle so stale data is never seen as valid
`timescale 1ns/1ps
module key_host (
  input wire logic i_clk, // Clock
  input wire logic i_go, // Start one key write
  input wire logic i_commit, // Follow the load with a commit
  input wire logic [lock_pkg::KEY_W-1:0] i_key, // Key to send
  output logic o_key_load = 1'b0, // Load strobe
  output logic [lock_pkg::KEY_W-1:0] o_key_data = '0, // Key lines
  output logic o_key_commit = 1'b0 // Commit strobe
);
  always @(posedge i_clk) begin
    o_key_load <= i_go;
    o_key_data <= i_go ? i_key : ~o_key_data;
    o_key_commit <= o_key_load && i_commit;
  end
endmodule // key_host

/* verification/debug_port_security_lock_tb.sv */
// Purpose: Self-checking bench for the security lock
// Assumes: Host model drives the key lines
// Notes: Readback and block results are checked from queues
`timescale 1ns/1ps
module debug_port_security_lock_tb;
  logic i_ref_clk = 0, i_rst = 1, i_cell_restore = 0, i_prot_set = 0, i_full_erase = 0, i_blk_req = 0;
  logic i_test_req = 1, i_readback_req = 0, go = 0, with_commit = 0, i_key_load, i_key_commit;
  logic o_locked, o_armed, o_key_rejected, o_blk_grant, o_blk_deny, o_test_en, o_jtag_en, o_swd_en;
  logic o_swv_en, o_cfg_illegal, o_readback_valid;
  logic [31:0] i_cell_data = 0, i_key_data, o_readback_data, rb_q[$];
  logic [1:0] i_prot_image = 0, i_prot_level = 0, i_dbg_sel = 0, i_trace_sel = 0, o_prot_level, blk_q[$];
  logic [3:0] i_blk_idx = 0;
  logic [15:0] i_blk_permit = 0;
  logic [4:0] o_trace_oe;
  int n_fail = 0, num_checks = 0, seed = 59158;
  always #5 i_ref_clk = ~i_ref_clk;
  key_host i_host (.i_clk(i_ref_clk), .i_go(go), .i_commit(with_commit), .i_key(lock_pkg::KEY_PATTERN),
    .o_key_load(i_key_load), .o_key_data(i_key_data), .o_key_commit(i_key_commit));
  debug_port_security_lock i_dut (.*);
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task finish_test;
    if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task reset_to(input logic rs, input logic [31:0] cells);
    @(posedge i_ref_clk);
    i_rst <= 1;
    i_cell_restore <= rs;
    i_cell_data <= cells;
    repeat (20) @(posedge i_ref_clk);
    i_rst <= 0;
    i_cell_restore <= 0;
    tick(1);
  endtask
  task ports(input logic lk);
    logic ok;
    logic tq;
    for (int d = 0; d < 4; d++) begin
      for (int t = 0; t < 4; t++) begin
        tq = 1'($random(seed));
        @(posedge i_ref_clk);
        i_dbg_sel <= d[1:0];
        i_trace_sel <= t[1:0];
        i_test_req <= tq;
        tick(1);
        ok = !lk && d != 3 && t != 3 && !(d == 1 && t == 1);
        check({o_test_en, o_jtag_en, o_swd_en, o_swv_en, o_trace_oe},
          {!lk && tq, ok && d == 1, ok && d == 2, ok && t == 1, ok && t == 2 ? 5'h1f : 5'h00});
        if (!lk) check(o_cfg_illegal, !ok);
      end
    end
  endtask
  task blk_burst(input logic lk);
    logic [15:0] p;
    logic [3:0] x;
    for (int k = 0; k < 8; k++) begin
      p = 16'($random(seed));
      x = 4'($random(seed));
      @(posedge i_ref_clk);
      i_blk_permit <= p;
      i_blk_idx <= x;
      i_blk_req <= 1;
      blk_q.push_back(!lk && p[x] ? 2'b10 : 2'b01);
    end
    @(posedge i_ref_clk);
    i_blk_req <= 0;
    tick(2);
  endtask
  task read_cells(input logic [31:0] exp);
    @(posedge i_ref_clk);
    i_readback_req <= 1;
    rb_q.push_back(exp);
    @(posedge i_ref_clk);
    i_readback_req <= 0;
    tick(2);
  endtask
  task host_load(input logic cm);
    @(posedge i_ref_clk);
    go <= 1;
    with_commit <= cm;
    @(posedge i_ref_clk);
    go <= 0;
    tick(1);
  endtask
  always @(negedge i_ref_clk) begin
    if (o_readback_valid === 1'b1) begin
      if (rb_q.size() == 0) check(1, 0);
      else check(o_readback_data, rb_q.pop_front());
    end
    if ((o_blk_grant | o_blk_deny) === 1'b1) begin
      if (blk_q.size() == 0) check(1, 0);
      else check({o_blk_grant, o_blk_deny}, blk_q.pop_front());
    end
  end
  initial begin
    #100000;
    n_fail++;
    finish_test;
  end
  initial begin
    reset_to(1, 0);
    check(o_locked, 0);
    for (int n = 4; n < 6; n++) begin
      reset_to(1, lock_pkg::KEY_PATTERN ^ ((32'h0000_0001 << n) - 1));
      check(o_locked, n == 4);
    end
    ports(0);
    blk_burst(0);
    read_cells(lock_pkg::KEY_PATTERN ^ 32'h0000_001f);
    @(posedge i_ref_clk);
    i_prot_level <= 2'h2;
    i_prot_set <= 1;
    @(posedge i_ref_clk);
    i_prot_level <= 2'h0;
    @(posedge i_ref_clk);
    i_prot_set <= 0;
    #1;
    check(o_prot_level, 2'h2);
    host_load(0);
    check(o_key_rejected, 1);
    @(posedge i_ref_clk);
    i_full_erase <= 1;
    @(posedge i_ref_clk);
    i_full_erase <= 0;
    #1;
    check(o_prot_level, 2'h0);
    host_load(1);
    for (int k = 0; k < 10 && o_armed !== 1'b1; k++) tick(1);
    check(o_armed, 1);
    if (o_armed !== 1'b1) finish_test;
    @(posedge i_ref_clk);
    i_dbg_sel <= 2'h1;
    i_trace_sel <= 2'h0;
    tick(1);
    check(o_jtag_en, 1);
    reset_to(0, 0);
    check({o_locked, o_armed}, 2'b10);
    ports(1);
    blk_burst(1);
    host_load(1);
    check(o_key_rejected, 1);
    read_cells(lock_pkg::KEY_PATTERN);
    check(rb_q.size() + blk_q.size(), 0);
    finish_test;
  end
endmodule // debug_port_security_lock_tb
